// *** common/supervisor_pkg.sv ***
// Shared constants and types for the charge and boost mode supervisor.
package supervisor_pkg;
	// Register map.
	localparam logic [7:0] FAULT_FLAGS_ADDR = 8'h0c;
	localparam logic [7:0] FAULT_FLAGS_RESET = 8'h00;
	// Fault flag bit positions.
	localparam int SYS_OVP_BIT = 0;
	localparam int TEMP_FAULT_BIT = 1;
	localparam int SHORT_BIT = 2;
	localparam int CELL_OVP_BIT = 3;
	localparam int TIMER_BIT = 4;
	localparam int THERMAL_BIT = 5;
	// Mode select codes.
	localparam logic [1:0] HEALTH_MODE_CHARGER = 2'h1;
	localparam logic [1:0] HEALTH_MODE_CHECK = 2'h2;
	localparam logic [1:0] CHEM_SUPERCAP = 2'h0;
	localparam logic [1:0] CHEM_LITHIUM = 2'h1;
	localparam logic [1:0] CHEM_NIMH = 2'h2;
	localparam logic [2:0] WAKE_SEL_RESET = 3'h7;
	// Timing, in ns, and clock period.
	localparam int CLOCK_PERIOD_NS = 100;
	localparam int INIT_DELAY_NS = 50000;
	localparam int STARTUP_TIME_NS = 30000;
	localparam int INIT_CYCLES = (INIT_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int STARTUP_CYCLES = STARTUP_TIME_NS / CLOCK_PERIOD_NS;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;

	// Charger phases, one-hot.
	typedef enum logic [4:0] {
		CHG_IDLE = 5'b0_0001,
		CHG_CC = 5'b0_0010,
		CHG_CV = 5'b0_0100,
		CHG_DONE = 5'b0_1000,
		CHG_RECHG = 5'b1_0000
	} charge_state_t;

	// Boost phases, one-hot.
	typedef enum logic [3:0] {
		BST_OFF = 4'b0001,
		BST_STANDBY = 4'b0010,
		BST_LOCKOUT = 4'b0100,
		BST_RUN = 4'b1000
	} boost_state_t;
endpackage : supervisor_pkg

// *** src/charge_boost_mode_supervisor.sv ***
// Charge and boost mode supervisor logic.
//
// Summary of operation
// - Below target, supercap charges constant current.
// - At target go CV; end below termination.
// - Recharge off: restart needs enable toggle.
// - Recharge on: restart below recharge threshold.
// - Thermistor source on in charger/health mode.
// - Charge only inside thermistor window.
// - Temperature out: stop, flag, auto resume.
// - Any flagged fault pauses charging, sets bit.
// - Reverse guard pauses, freezes timer, no flag.
// - Rail overvoltage sets flag, pauses charging.
// - Lithium low after limit: short flag.
// - Cell overvoltage per chemistry sets flag.
// - Lithium safety timer expiry sets flag.
// - Overtemp flags, pauses, resets charge timer.
// - Boost needs pin and bit; wake enters.
// - Lockout threshold chosen by rail level.
// - Start-up finishes within fixed time.
// - Auto wake below min of thresholds.
// - Boosting returns standby above standby threshold.
// - Wake select resets to above-target code.
// - Initialization delay after leaving shutdown.
// - Charger enable needs pin, mode, rail, supply.
`timescale 1ns/1ps
`default_nettype none

module charge_boost_mode_supervisor
	import supervisor_pkg::*;
#(
	parameter int TIMER_WIDTH = 16,
	parameter int SHORT_LIMIT = 18000,
	parameter int SAFETY_LIMIT = 36000
)
(
	// Clock, reset and enable.
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	// Enable pins and configuration bits.
	input wire logic charger_enable_pin,
	input wire logic charger_enable_bit,
	input wire logic [1:0] charger_health_mode_sel,
	input wire logic [1:0] chemistry_sel,
	input wire logic recharge_select,
	input wire logic boost_enable_pin,
	input wire logic boost_enable_bit,
	input wire logic wake_sel_write,
	input wire logic [2:0] wake_sel_data,
	// Comparator outputs, asynchronous.
	input wire logic [9:0] comparators,
	input wire logic supply_ok_cmp,
	input wire logic lockout_hi_cmp,
	input wire logic lockout_lo_cmp,
	input wire logic rail_ref_cmp,
	input wire logic standby_cmp,
	// Register read port.
	input wire logic [7:0] reg_addr,
	output logic [7:0] reg_rdata,
	// Outputs.
	output logic charging,
	output logic constant_voltage,
	output logic thermistor_source_on,
	output logic boost_switching,
	output logic boost_starting,
	output logic device_ready,
	output logic [2:0] wake_threshold_sel
);

	// Comparator bit map.
	localparam int CMP_BELOW_TARGET = 0;
	localparam int CMP_TERM_LOW = 1;
	localparam int CMP_BELOW_RECHG = 2;
	localparam int CMP_TS_IN_WINDOW = 3;
	localparam int CMP_RAIL_LOW_REV = 4;
	localparam int CMP_RAIL_OVP = 5;
	localparam int CMP_CELL_LOW = 6;
	localparam int CMP_CELL_OVP = 7;
	localparam int CMP_JUNCTION_HOT = 8;
	localparam int CMP_RAIL_BELOW_WAKE = 9;
	// Remaining comparators are derived from lockout and standby references below.

	// ---------------------------------------------------------------
	// State record
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [9:0] sync1;
		logic [9:0] sync2;
		logic en_prev;
		charge_state_t chg;
		boost_state_t bst;
		logic [TIMER_WIDTH-1:0] chg_timer;
		logic [TIMER_WIDTH-1:0] init_cnt;
		logic [TIMER_WIDTH-1:0] start_cnt;
		logic [7:0] flags;
		logic [7:0] rdata;
		logic charging;
		logic cv;
		logic ts_on;
		logic switching;
		logic starting;
		logic ready;
		logic [2:0] wake_sel;
	} state_t;

	state_t cur;
	state_t next_cur;

	// Comparator helper: synchronized view only.
	function automatic logic cmp(input logic [9:0] v, input int idx);
		cmp = v[idx];
	endfunction : cmp

	logic charger_on;
	logic boost_on;
	logic en_level;
	logic flag_pause;
	logic temp_ok;
	logic reverse;
	logic lithium;
	logic boost_lockout_ok;
	logic rail_above_standby;
	logic standby_cmp_sync;
	logic supply_ok_sync;

	// Enable qualifiers and fault summary.
	always_comb
	begin
		en_level = charger_enable_pin & charger_enable_bit;
		charger_on = en_level & (charger_health_mode_sel == HEALTH_MODE_CHARGER)
			& ~cmp(cur.sync2, CMP_RAIL_OVP) & supply_ok_sync;
		boost_on = boost_enable_pin & boost_enable_bit;
		temp_ok = cmp(cur.sync2, CMP_TS_IN_WINDOW);
		reverse = cmp(cur.sync2, CMP_RAIL_LOW_REV);
		lithium = (chemistry_sel == CHEM_LITHIUM);
		flag_pause = (cur.flags != FAULT_FLAGS_RESET) | ~temp_ok | reverse;
	end

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	always_comb
	begin
		next_cur = cur;
		// Two-stage synchronizer for every comparator.
		next_cur.sync1 = comparators;
		next_cur.sync2 = cur.sync1;
		next_cur.en_prev = en_level;

		// Wake select register, reset to the above-target code.
		if (wake_sel_write)
		begin
			next_cur.wake_sel = wake_sel_data;
		end

		// Initialization delay after leaving shutdown.
		if (!cur.ready)
		begin
			if (cur.init_cnt == TIMER_WIDTH'(INIT_CYCLES - 1))
			begin
				next_cur.ready = 1'b1;
			end
			else
			begin
				next_cur.init_cnt = cur.init_cnt + COUNT_ONE[TIMER_WIDTH-1:0];
			end
		end

		// Live fault flags; latched short and timer flags stay until toggle.
		next_cur.flags[TEMP_FAULT_BIT] = charger_on & ~temp_ok;
		next_cur.flags[SYS_OVP_BIT] = cmp(cur.sync2, CMP_RAIL_OVP);
		next_cur.flags[THERMAL_BIT] = cmp(cur.sync2, CMP_JUNCTION_HOT);
		next_cur.flags[CELL_OVP_BIT] = charger_on & cmp(cur.sync2, CMP_CELL_OVP);
		if (lithium && cur.chg_timer >= TIMER_WIDTH'(SHORT_LIMIT) && cmp(cur.sync2, CMP_CELL_LOW))
		begin
			next_cur.flags[SHORT_BIT] = 1'b1;
		end
		if (lithium && cur.chg_timer >= TIMER_WIDTH'(SAFETY_LIMIT))
		begin
			next_cur.flags[TIMER_BIT] = 1'b1;
		end
		// Toggle of the enable clears latched flags and restarts.
		if (en_level != cur.en_prev)
		begin
			next_cur.flags[SHORT_BIT] = 1'b0;
			next_cur.flags[TIMER_BIT] = 1'b0;
			next_cur.chg = CHG_IDLE;
			next_cur.chg_timer = COUNT_ZERO[TIMER_WIDTH-1:0];
		end
		else if (!charger_on || !cur.ready)
		begin
			next_cur.chg = CHG_IDLE;
			next_cur.chg_timer = COUNT_ZERO[TIMER_WIDTH-1:0];
		end
		else
		begin
			case (cur.chg)
				CHG_IDLE:
				begin
					next_cur.chg = cmp(cur.sync2, CMP_BELOW_TARGET) ? CHG_CC : CHG_CV;
				end
				CHG_CC:
				begin
					if (!cmp(cur.sync2, CMP_BELOW_TARGET))
					begin
						next_cur.chg = CHG_CV;
					end
				end
				CHG_CV:
				begin
					if (cmp(cur.sync2, CMP_TERM_LOW) && !flag_pause)
					begin
						next_cur.chg = recharge_select ? CHG_RECHG : CHG_DONE;
					end
				end
				CHG_RECHG:
				begin
					if (cmp(cur.sync2, CMP_BELOW_RECHG))
					begin
						next_cur.chg = CHG_CC;
					end
				end
				default:
				begin
					next_cur.chg = CHG_DONE;
				end
			endcase
			// Charge timer: reset by overtemp, frozen by reverse guard.
			if (cmp(cur.sync2, CMP_JUNCTION_HOT))
			begin
				next_cur.chg_timer = COUNT_ZERO[TIMER_WIDTH-1:0];
			end
			else if (!reverse && (cur.chg == CHG_CC || cur.chg == CHG_CV) && cur.chg_timer != '1)
			begin
				next_cur.chg_timer = cur.chg_timer + COUNT_ONE[TIMER_WIDTH-1:0];
			end
		end
		next_cur.charging = (next_cur.chg == CHG_CC || next_cur.chg == CHG_CV) & ~flag_pause;
		next_cur.cv = (next_cur.chg == CHG_CV);
		// Thermistor source only in charger or health-check mode.
		next_cur.ts_on = en_level & ((charger_health_mode_sel == HEALTH_MODE_CHARGER)
			| (charger_health_mode_sel == HEALTH_MODE_CHECK));

		// Boost sequencing; wake comparator already encodes min of thresholds.
		if (!boost_on || !cur.ready)
		begin
			next_cur.bst = BST_OFF;
		end
		else
		begin
			case (cur.bst)
				BST_OFF:
				begin
					next_cur.bst = BST_STANDBY;
				end
				BST_STANDBY:
				begin
					if (cmp(cur.sync2, CMP_RAIL_BELOW_WAKE))
					begin
						next_cur.bst = BST_LOCKOUT;
						next_cur.start_cnt = COUNT_ZERO[TIMER_WIDTH-1:0];
					end
				end
				BST_LOCKOUT:
				begin
					// Lockout comparator selection is by rail level.
					if (boost_lockout_ok)
					begin
						next_cur.bst = BST_RUN;
					end
				end
				default:
				begin
					if (rail_above_standby)
					begin
						next_cur.bst = BST_STANDBY;
					end
					else if (cur.start_cnt != TIMER_WIDTH'(STARTUP_CYCLES))
					begin
						next_cur.start_cnt = cur.start_cnt + COUNT_ONE[TIMER_WIDTH-1:0];
					end
				end
			endcase
		end
		next_cur.switching = (next_cur.bst == BST_RUN);
		next_cur.starting = (next_cur.bst == BST_RUN) && (next_cur.start_cnt != TIMER_WIDTH'(STARTUP_CYCLES));

		// Register read port.
		if (reg_addr == FAULT_FLAGS_ADDR)
		begin
			next_cur.rdata = cur.flags;
		end
		else
		begin
			next_cur.rdata = FAULT_FLAGS_RESET;
		end
	end

	// Extra synchronized comparators for lockout and standby.
	logic [2:0] bsync1;
	logic [2:0] bsync2;
	// Two flops; bit 0 rail above reference, 1 cell above low lockout, 2 cell above high lockout.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			bsync1 <= 3'h0;
			bsync2 <= 3'h0;
		end
		else if (clk_en)
		begin
			bsync1 <= {lockout_hi_cmp, lockout_lo_cmp, rail_ref_cmp};
			bsync2 <= bsync1;
		end
	end
	always_comb
	begin
		boost_lockout_ok = bsync2[0] ? bsync2[1] : bsync2[2];
		rail_above_standby = standby_cmp_sync;
	end

	// Standby and supply comparator synchronizers; supply reads low until proven good.
	logic standby_s1;
	logic supply_s1;
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			standby_s1 <= 1'b0;
			standby_cmp_sync <= 1'b0;
			supply_s1 <= 1'b0;
			supply_ok_sync <= 1'b0;
		end
		else if (clk_en)
		begin
			standby_s1 <= standby_cmp;
			standby_cmp_sync <= standby_s1;
			supply_s1 <= supply_ok_cmp;
			supply_ok_sync <= supply_s1;
		end
	end

	// State register.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			cur <= '0;
			cur.chg <= CHG_IDLE;
			cur.bst <= BST_OFF;
			cur.flags <= FAULT_FLAGS_RESET;
			cur.wake_sel <= WAKE_SEL_RESET;
		end
		else if (clk_en)
		begin
			cur <= next_cur;
		end
	end

	// Outputs straight from flops.
	always_comb
	begin
		reg_rdata = cur.rdata;
		charging = cur.charging;
		constant_voltage = cur.cv;
		thermistor_source_on = cur.ts_on;
		boost_switching = cur.switching;
		boost_starting = cur.starting;
		device_ready = cur.ready;
		wake_threshold_sel = cur.wake_sel;
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	a_pause_on_flag: assert property (@(posedge clock) disable iff (rst)
		clk_en && cur.flags != FAULT_FLAGS_RESET |=> !cur.charging)
		else $error("charging with a fault flag set");
	a_ts_source_mode: assert property (@(posedge clock) disable iff (rst)
		cur.ts_on |-> $past(charger_health_mode_sel) != 2'h0)
		else $error("thermistor source on outside mode");
	a_boost_gate: assert property (@(posedge clock) disable iff (rst)
		cur.switching |-> $past(boost_on))
		else $error("boost switching while disabled");
	a_ovp_flag: assert property (@(posedge clock) disable iff (rst)
		clk_en && cmp(cur.sync2, CMP_RAIL_OVP) |=> cur.flags[SYS_OVP_BIT])
		else $error("system overvoltage flag missed");
	a_ready_delay: assert property (@(posedge clock) disable iff (rst)
		cur.ready |-> cur.init_cnt == TIMER_WIDTH'(INIT_CYCLES - 1))
		else $error("ready before init delay");
	a_wake_reset: assert property (@(posedge clock) disable iff (rst)
		$fell(rst) |-> cur.wake_sel == WAKE_SEL_RESET)
		else $error("wake select reset wrong");
	a_short_toggle: assert property (@(posedge clock) disable iff (rst)
		clk_en && en_level != cur.en_prev |=> !cur.flags[SHORT_BIT])
		else $error("short flag survived toggle");
	a_charge_enable: assert property (@(posedge clock) disable iff (rst)
		cur.charging |-> $past(charger_on))
		else $error("charging while charger disabled");

endmodule : charge_boost_mode_supervisor

`default_nettype wire

// *** verification/host_model.sv ***
// Host model that drives the enable pins and configuration bits.
`timescale 1ns/1ps
`default_nettype none
module host_model
(
	// Clock.
	input wire logic clock,
	// Charger controls.
	output logic charger_enable_pin,
	output logic charger_enable_bit,
	output logic [1:0] charger_health_mode_sel,
	output logic [1:0] chemistry_sel,
	output logic recharge_select,
	// Boost controls.
	output logic boost_enable_pin,
	output logic boost_enable_bit,
	output logic wake_sel_write,
	output logic [2:0] wake_sel_data
);
	import supervisor_pkg::*;
	// ----------------------------------------
	// Drive tasks
	// ----------------------------------------
	// All controls start released, so nothing runs before the bench asks.
	initial
	begin
		charger_enable_pin = 1'b0;
		charger_enable_bit = 1'b0;
		charger_health_mode_sel = 2'h0;
		chemistry_sel = CHEM_SUPERCAP;
		recharge_select = 1'b0;
		boost_enable_pin = 1'b0;
		boost_enable_bit = 1'b0;
		wake_sel_write = 1'b0;
		wake_sel_data = 3'h0;
	end
	// Drives the charger pin, mode and recharge select; the enable bit is always set.
	task automatic set_charger(input logic pin, input logic [1:0] mode, input logic rech);
		@(posedge clock);
		charger_enable_pin <= pin;
		charger_enable_bit <= 1'b1;
		charger_health_mode_sel <= mode;
		recharge_select <= rech;
	endtask : set_charger
	// The pin is held low for four cycles; the enable is not synchronized, so each pin edge is a toggle.
	task automatic toggle_charger();
		@(posedge clock);
		charger_enable_pin <= 1'b0;
		repeat (4) @(posedge clock);
		charger_enable_pin <= 1'b1;
	endtask : toggle_charger
	// Boost needs both pin and bit.
	task automatic set_boost(input logic pin, input logic bit_v);
		@(posedge clock);
		boost_enable_pin <= pin;
		boost_enable_bit <= bit_v;
	endtask : set_boost
	// One-cycle write pulse.
	task automatic write_wake(input logic [2:0] code);
		@(posedge clock);
		wake_sel_write <= 1'b1;
		wake_sel_data <= code;
		@(posedge clock);
		wake_sel_write <= 1'b0;
	endtask : write_wake
endmodule : host_model
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the charge and boost mode supervisor.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import supervisor_pkg::*;
	// ----------------------------------------
	// Signals and table
	// ----------------------------------------
	// Comparator lanes as the bench drives them; they must follow the design's lane map.
	// Bit 10 is the supply comparator, which has a port of its own.
	localparam logic [10:0] C_BT = 11'h001;
	localparam logic [10:0] C_TERM = 11'h002;
	localparam logic [10:0] C_RCH = 11'h004;
	localparam logic [10:0] C_TSOK = 11'h008;
	localparam logic [10:0] C_REV = 11'h010;
	localparam logic [10:0] C_OVP = 11'h020;
	localparam logic [10:0] C_COV = 11'h080;
	localparam logic [10:0] C_HOT = 11'h100;
	localparam logic [10:0] C_WAKE = 11'h200;
	localparam logic [10:0] C_SUP = 11'h400;
	localparam logic [10:0] C_NRM = C_SUP | C_TSOK | C_BT;
	typedef struct {logic [1:0] mode; logic pin; logic [10:0] cmp; logic chg; logic ts; logic ts_care; logic [7:0] fmask; logic [7:0] fexp;} row_t;
	logic supply_ok_cmp, lockout_hi_cmp, lockout_lo_cmp, rail_ref_cmp, standby_cmp;
	logic clock, rst, clk_en, charging, constant_voltage, thermistor_source_on, boost_switching, boost_starting;
	logic device_ready, c_pin, c_bit, recharge_select, b_pin, b_bit, wake_sel_write;
	logic [1:0] mode_sel, chemistry_sel;
	logic [2:0] wake_sel_data, wake_threshold_sel;
	logic [9:0] comparators;
	logic [7:0] reg_addr, reg_rdata, flags;
	int fail_count, tests_run;
	row_t rows [11];
	host_model host (.clock(clock), .charger_enable_pin(c_pin), .charger_enable_bit(c_bit),
		.charger_health_mode_sel(mode_sel), .chemistry_sel(chemistry_sel), .recharge_select(recharge_select),
		.boost_enable_pin(b_pin), .boost_enable_bit(b_bit), .wake_sel_write(wake_sel_write),
		.wake_sel_data(wake_sel_data));
	charge_boost_mode_supervisor dut (.clock(clock), .rst(rst), .clk_en(clk_en), .charger_enable_pin(c_pin),
		.charger_enable_bit(c_bit), .charger_health_mode_sel(mode_sel), .chemistry_sel(chemistry_sel),
		.recharge_select(recharge_select), .boost_enable_pin(b_pin), .boost_enable_bit(b_bit),
		.wake_sel_write(wake_sel_write), .wake_sel_data(wake_sel_data), .comparators(comparators),
		.supply_ok_cmp(supply_ok_cmp), .lockout_hi_cmp(lockout_hi_cmp), .lockout_lo_cmp(lockout_lo_cmp),
		.rail_ref_cmp(rail_ref_cmp), .standby_cmp(standby_cmp),
		.reg_addr(reg_addr), .reg_rdata(reg_rdata), .charging(charging), .constant_voltage(constant_voltage),
		.thermistor_source_on(thermistor_source_on), .boost_switching(boost_switching),
		.boost_starting(boost_starting), .device_ready(device_ready), .wake_threshold_sel(wake_threshold_sel));
	// 10 MHz clock.
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_bit
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_byte
	// Comparators pass two synchronizer flops and the state flop, so six edges is ample.
	task automatic step(input logic [10:0] cmp);
		@(posedge clock);
		comparators <= cmp[9:0];
		supply_ok_cmp <= cmp[10];
		repeat (6) @(posedge clock);
		#1;
	endtask : step
	// Read data is registered one edge after the address is taken.
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		@(posedge clock);
		reg_addr <= addr;
		repeat (2) @(posedge clock);
		#1;
		data = reg_rdata;
	endtask : read_reg
	// Bounded wait for the end of initialization.
	task automatic wait_ready(input int limit);
		for (int n = 0; n < limit && device_ready !== 1'b1; n++)
			@(posedge clock);
		#1;
		check_bit(device_ready, 1'b1);
	endtask : wait_ready
	task automatic final_report();
		$display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report
	// The run needs about 1350 cycles; this limit of 30000 cycles leaves over twenty times that.
	initial
	begin
		#3_000_000;
		fail_count++;
		final_report();
	end
	// Main sequence.
	initial
	begin
		rst = 1'b1;
		clk_en = 1'b1;
		comparators = C_NRM[9:0];
		supply_ok_cmp = 1'b1;
		lockout_hi_cmp = 1'b0;
		lockout_lo_cmp = 1'b0;
		rail_ref_cmp = 1'b0;
		standby_cmp = 1'b0;
		reg_addr = 8'h00;
		fail_count = 0;
		tests_run = 0;
		rows = '{'{2'h1, 1'b1, C_NRM | C_REV, 1'b0, 1'b1, 1'b1, 8'hff, 8'h00},
			'{2'h1, 1'b1, C_NRM, 1'b1, 1'b1, 1'b1, 8'h00, 8'h00},
			'{2'h1, 1'b1, C_SUP | C_BT, 1'b0, 1'b1, 1'b1, 8'h02, 8'h02},
			'{2'h1, 1'b1, C_NRM, 1'b1, 1'b1, 1'b1, 8'h00, 8'h00},
			'{2'h1, 1'b1, C_NRM | C_HOT, 1'b0, 1'b1, 1'b1, 8'h20, 8'h20},
			'{2'h2, 1'b1, C_NRM, 1'b0, 1'b1, 1'b1, 8'h00, 8'h00},
			'{2'h0, 1'b1, C_NRM, 1'b0, 1'b0, 1'b1, 8'h00, 8'h00},
			'{2'h1, 1'b0, C_NRM, 1'b0, 1'b0, 1'b1, 8'h00, 8'h00},
			'{2'h1, 1'b1, C_TSOK | C_BT, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00},
			'{2'h1, 1'b1, C_NRM | C_COV, 1'b0, 1'b0, 1'b0, 8'h08, 8'h08},
			'{2'h1, 1'b1, C_NRM | C_OVP, 1'b0, 1'b0, 1'b0, 8'h01, 8'h01}};
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		wait_ready(INIT_CYCLES + 20);
		foreach (rows[i])
		begin
			host.set_charger(rows[i].pin, rows[i].mode, 1'b0);
			step(rows[i].cmp);
			check_bit(charging, rows[i].chg);
			if (rows[i].ts_care === 1'b1)
				check_bit(thermistor_source_on, rows[i].ts);
			read_reg(FAULT_FLAGS_ADDR, flags);
			check_byte(flags & rows[i].fmask, rows[i].fexp);
			$display("row %0d done", i);
		end
		// Second reset, with enable held low for a while during the init count.
		@(posedge clock);
		rst <= 1'b1;
		comparators <= C_NRM[9:0];
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		#1;
		check_byte({5'h00, wake_threshold_sel}, {5'h00, WAKE_SEL_RESET});
		read_reg(FAULT_FLAGS_ADDR, flags);
		check_byte(flags, FAULT_FLAGS_RESET);
		read_reg(8'hff, flags);
		check_byte(flags, 8'h00);
		clk_en <= 1'b0;
		repeat (100) @(posedge clock);
		clk_en <= 1'b1;
		repeat (INIT_CYCLES - 40) @(posedge clock);
		#1;
		check_bit(device_ready, 1'b0);
		wait_ready(80);
		$display("reset test done");
		// Supercap profile: constant current, constant voltage, end, restart.
		host.set_charger(1'b1, HEALTH_MODE_CHARGER, 1'b0);
		step(C_NRM);
		check_bit(charging & ~constant_voltage, 1'b1);
		step(C_SUP | C_TSOK);
		check_bit(charging & constant_voltage, 1'b1);
		step(C_SUP | C_TSOK | C_TERM);
		check_bit(charging, 1'b0);
		step(C_NRM | C_RCH);
		check_bit(charging, 1'b0);
		host.toggle_charger();
		step(C_NRM);
		check_bit(charging & ~constant_voltage, 1'b1);
		host.set_charger(1'b1, HEALTH_MODE_CHARGER, 1'b1);
		step(C_SUP | C_TSOK | C_TERM);
		check_bit(charging, 1'b0);
		step(C_NRM | C_RCH);
		check_bit(charging, 1'b1);
		$display("profile test done");
		// Wake code write and half-enabled boost.
		host.write_wake(3'h3);
		step(C_NRM);
		check_byte({5'h00, wake_threshold_sel}, 8'h03);
		host.set_boost(1'b1, 1'b0);
		step(C_NRM | C_WAKE);
		check_bit(boost_switching | boost_starting, 1'b0);
		host.set_boost(1'b0, 1'b1);
		step(C_NRM | C_WAKE);
		check_bit(boost_switching | boost_starting, 1'b0);
		// Full boost: rail above reference, cell above low lockout, then standby return.
		@(posedge clock);
		rail_ref_cmp <= 1'b1;
		lockout_lo_cmp <= 1'b1;
		step(C_NRM);
		host.set_boost(1'b1, 1'b1);
		step(C_NRM | C_WAKE);
		check_bit(boost_switching, 1'b1);
		check_bit(boost_starting, 1'b1);
		@(posedge clock);
		standby_cmp <= 1'b1;
		step(C_NRM);
		check_bit(boost_switching, 1'b0);
		$display("boost test done");
		final_report();
	end
endmodule : tb
`default_nettype wire
